// *** common/sbp_pkg.sv ***
// Package with register map, field layout, encodings and bus carriers of the serial-bus port status block.
package sbp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // High-speed rate encoding; codes 3'h6 and 3'h7 are reserved.
  localparam logic [2:0] RATE_S100 = 3'h0;
  localparam logic [2:0] RATE_S200 = 3'h1;
  localparam logic [2:0] RATE_S400 = 3'h2;
  localparam logic [2:0] RATE_S800 = 3'h3;
  localparam logic [2:0] RATE_S1600 = 3'h4;
  localparam logic [2:0] RATE_S3200 = 3'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: connection debounce time and the clock rate it is counted at.
  localparam longint DEBOUNCE_MS = 341;
  localparam longint CLK_HZ = 20000000;
  localparam longint DEBOUNCE_CYC_DEF = (DEBOUNCE_MS * CLK_HZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] ADDR_PORT_SEL = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_ERRCNT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Control register fields.
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_SLEEP_EN_BIT = 3;
  // Status register fields.
  localparam int STAT_PLUG_BIT = 0;
  localparam int STAT_CAP_LSB = 1;
  localparam int STAT_FAST_BIT = 4;
  localparam int STAT_CONN_BIT = 5;
  localparam int STAT_RXVALID_BIT = 6;
  localparam int STAT_LEGACY_BIT = 7;
  localparam int STAT_ASLEEP_BIT = 8;
  localparam int STAT_UNSTABLE_BIT = 9;
  localparam int STAT_BILINGUAL_BIT = 10;
  // Interrupt status and mask fields.
  localparam int IRQ_W = 4;
  localparam int IRQ_UNSTABLE = 0;
  localparam int IRQ_SATURATED = 1;
  localparam int IRQ_CONN = 2;
  localparam int IRQ_SLEEP = 3;

  localparam logic [7:0] ERRCNT_MAX = 8'hFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and port carriers.
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } sbp_ahb_in_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } sbp_ahb_out_t;

  typedef struct packed {
    logic line_connect;
    logic receive_valid;
    logic fast_mode;
    logic bilingual;
    logic neg_fail;
    logic sync_fail;
    logic bad_codeword;
    logic sleep_req;
  } sbp_port_in_t;

  typedef struct packed {
    logic [2:0] train_rate;
    logic connected;
    logic asleep;
  } sbp_port_out_t;

endpackage : sbp_pkg

// *** core/sbp_port_status.sv ***
// Per-port status and control register bank of a serial-bus physical layer, with an AHB-Lite slave.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module sbp_port_status
  import sbp_pkg::*;
#(
  parameter int NUM_PORTS = 3,
  parameter logic [2:0] CAP_RATE = RATE_S400,
  parameter longint DEBOUNCE_CYC = DEBOUNCE_CYC_DEF
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave.
  input wire sbp_ahb_in_t ahb_in,
  output sbp_ahb_out_t ahb_out,
  // Port line conditions and per-port results.
  input wire sbp_port_in_t [NUM_PORTS-1:0] port_in,
  output sbp_port_out_t [NUM_PORTS-1:0] port_out,
  // Sleep-enable strap, caught once after reset.
  input wire logic sleep_strap,
  // Remote access read of an error counter.
  input wire logic remote_rd,
  input wire logic [1:0] remote_port,
  output logic [7:0] remote_data,
  // Interrupt.
  output logic irq
);

  localparam int DEB_W = $clog2(DEBOUNCE_CYC + 1);
  localparam int SEL_W = 2;

  typedef struct packed {
    logic [2:0] rate_limit;
    logic [2:0] train_rate;
    logic sleep_en;
    logic unstable;
    logic asleep;
    logic connected;
    logic [7:0] errcnt;
    logic [DEB_W-1:0] deb;
  } sbp_port_state_t;

  typedef struct packed {
    sbp_port_state_t [NUM_PORTS-1:0] pt;
    logic [SEL_W-1:0] sel;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic [7:0] remote_data;
    logic strap_done;
  } sbp_state_t;

  sbp_state_t s;
  sbp_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Clamp a written rate to what the port can do; reserved codes also clamp.
  function automatic logic [2:0] sbp_clamp_rate(input logic [2:0] w);
    return (w > CAP_RATE) ? CAP_RATE : w;
  endfunction : sbp_clamp_rate

  // Status word of one port.
  function automatic logic [31:0] sbp_stat_word(input sbp_port_state_t p, input sbp_port_in_t pi);
    logic [31:0] w;
    w = 32'h0;
    w[STAT_PLUG_BIT] = 1'b1;
    w[STAT_CAP_LSB +: 3] = CAP_RATE;
    w[STAT_FAST_BIT] = p.connected & pi.fast_mode;
    w[STAT_CONN_BIT] = p.connected;
    w[STAT_RXVALID_BIT] = pi.receive_valid;
    w[STAT_LEGACY_BIT] = p.connected & pi.receive_valid & ~pi.fast_mode;
    w[STAT_ASLEEP_BIT] = p.asleep;
    w[STAT_UNSTABLE_BIT] = p.unstable;
    w[STAT_BILINGUAL_BIT] = pi.bilingual;
    return w;
  endfunction : sbp_stat_word

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode. Zero wait states, so every accepted address phase is answered next cycle.
  logic ap_take;
  logic sel_ok;
  logic dp_wr;
  assign ap_take = ahb_in.hsel & ahb_in.htrans[1] & ahb_in.hready;
  assign sel_ok = (s.sel < SEL_W'(NUM_PORTS));
  assign dp_wr = s.ap_valid & s.ap_write;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for all ports and the register file.
  always_comb begin
    logic [31:0] rd;
    logic [IRQ_W-1:0] ev;
    logic [7:0] cnt;
    logic rd_clr;
    logic w1c;
    logic wr_ctrl;
    rd = 32'h0;
    ev = '0;
    cnt = 8'h0;
    rd_clr = 1'b0;
    w1c = 1'b0;
    wr_ctrl = 1'b0;
    next_s = s;
    next_s.strap_done = 1'b1;

    // Address phase: read data is built now so that it leaves a flip-flop in the data phase.
    next_s.ap_valid = ap_take;
    next_s.ap_write = ahb_in.hwrite;
    next_s.ap_addr = ahb_in.haddr[7:0];
    if (ap_take && !ahb_in.hwrite) begin
      if (ahb_in.haddr[7:0] == ADDR_PORT_SEL) begin
        rd[SEL_W-1:0] = s.sel;
      end else if (ahb_in.haddr[7:0] == ADDR_CTRL && sel_ok) begin
        rd[CTRL_RATE_LSB +: 3] = s.pt[s.sel].rate_limit;
        rd[CTRL_SLEEP_EN_BIT] = s.pt[s.sel].sleep_en;
      end else if (ahb_in.haddr[7:0] == ADDR_STAT && sel_ok) begin
        rd = sbp_stat_word(s.pt[s.sel], port_in[s.sel]);
      end else if (ahb_in.haddr[7:0] == ADDR_ERRCNT && sel_ok) begin
        rd[7:0] = s.pt[s.sel].errcnt;
      end else if (ahb_in.haddr[7:0] == ADDR_IRQ_STAT) begin
        rd[IRQ_W-1:0] = s.irq_stat;
      end else if (ahb_in.haddr[7:0] == ADDR_IRQ_MASK) begin
        rd[IRQ_W-1:0] = s.irq_mask;
      end else begin
        rd = 32'h0;
      end
    end
    next_s.hrdata = rd;

    // Data-phase writes to the shared registers.
    if (dp_wr && s.ap_addr == ADDR_PORT_SEL) begin
      next_s.sel = ahb_in.hwdata[SEL_W-1:0];
    end else if (dp_wr && s.ap_addr == ADDR_IRQ_MASK) begin
      next_s.irq_mask = ahb_in.hwdata[IRQ_W-1:0];
    end

    // Per-port state; each port has its own copy and only the selected one takes writes.
    for (int p = 0; p < NUM_PORTS; p++) begin
      wr_ctrl = dp_wr && s.ap_addr == ADDR_CTRL && s.sel == SEL_W'(p);
      w1c = dp_wr && s.ap_addr == ADDR_STAT && s.sel == SEL_W'(p) && ahb_in.hwdata[STAT_UNSTABLE_BIT];
      rd_clr = (ap_take && !ahb_in.hwrite && ahb_in.haddr[7:0] == ADDR_ERRCNT && s.sel == SEL_W'(p))
             || (remote_rd && remote_port == SEL_W'(p));

      // Bilingual ports keep their field; writes are dropped silently.
      if (wr_ctrl && !port_in[p].bilingual) begin
        next_s.pt[p].rate_limit = sbp_clamp_rate(ahb_in.hwdata[CTRL_RATE_LSB +: 3]);
      end
      if (wr_ctrl) begin
        next_s.pt[p].sleep_en = ahb_in.hwdata[CTRL_SLEEP_EN_BIT];
      end
      if (!s.strap_done) begin
        next_s.pt[p].sleep_en = sleep_strap;
      end

      // A break of the line restarts the debounce, so only a steady connection counts.
      if (!port_in[p].line_connect) begin
        next_s.pt[p].deb = '0;
        next_s.pt[p].connected = 1'b0;
        ev[IRQ_CONN] = ev[IRQ_CONN] | s.pt[p].connected;
      end else if (!s.pt[p].connected) begin
        if (s.pt[p].deb == DEB_W'(DEBOUNCE_CYC - 1)) begin
          next_s.pt[p].connected = 1'b1;
          ev[IRQ_CONN] = 1'b1;
          // The training rate is taken only here, at a new fast-mode connection.
          if (port_in[p].fast_mode) begin
            next_s.pt[p].train_rate = port_in[p].bilingual ? RATE_S400 : s.pt[p].rate_limit;
          end
        end else begin
          next_s.pt[p].deb = s.pt[p].deb + DEB_W'(1);
        end
      end

      // The set comes after the clear so a failure in the clearing cycle is kept.
      if (w1c) begin
        next_s.pt[p].unstable = 1'b0;
      end
      if (port_in[p].neg_fail || port_in[p].sync_fail) begin
        next_s.pt[p].unstable = 1'b1;
        ev[IRQ_UNSTABLE] = 1'b1;
      end

      // A bad word in the cycle of the clearing read counts from zero, so none is lost.
      cnt = rd_clr ? 8'h0 : s.pt[p].errcnt;
      if (port_in[p].bad_codeword && cnt != ERRCNT_MAX) begin
        cnt = cnt + 8'h1;
        ev[IRQ_SATURATED] = ev[IRQ_SATURATED] | (cnt == ERRCNT_MAX);
      end
      next_s.pt[p].errcnt = cnt;

      // Sleep is entered on request only while enabled, and left when the request drops.
      if (port_in[p].sleep_req && s.pt[p].sleep_en && !s.pt[p].asleep) begin
        next_s.pt[p].asleep = 1'b1;
        ev[IRQ_SLEEP] = 1'b1;
      end else if (!port_in[p].sleep_req) begin
        next_s.pt[p].asleep = 1'b0;
      end
    end

    // Remote read answer; a read of an out-of-range port leaves the previous answer in place.
    if (remote_rd && remote_port < SEL_W'(NUM_PORTS)) begin
      next_s.remote_data = s.pt[remote_port].errcnt;
    end

    // Interrupt status: write-one-to-clear, with a new event winning over the clear.
    if (dp_wr && s.ap_addr == ADDR_IRQ_STAT) begin
      next_s.irq_stat = s.irq_stat & ~ahb_in.hwdata[IRQ_W-1:0];
    end
    next_s.irq_stat = next_s.irq_stat | ev;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; reset values are constants only, the strap is caught after release.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        s.pt[p].rate_limit <= CAP_RATE;
        s.pt[p].train_rate <= CAP_RATE;
      end
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign ahb_out.hrdata = s.hrdata;
  assign ahb_out.hreadyout = 1'b1;
  assign ahb_out.hresp = 1'b0;
  assign remote_data = s.remote_data;
  assign irq = |(s.irq_stat & s.irq_mask);
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_out[p].train_rate = s.pt[p].train_rate;
      port_out[p].connected = s.pt[p].connected;
      port_out[p].asleep = s.pt[p].asleep;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on port 0 and the bus answer; covers on ports 0 and 1 and the interrupt.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic rd_stat0;
  logic wr_rate0;
  assign rd_stat0 = ap_take && !ahb_in.hwrite && ahb_in.haddr[7:0] == ADDR_STAT && s.sel == '0;
  assign wr_rate0 = dp_wr && s.ap_addr == ADDR_CTRL && s.sel == '0;

  plug_reads_one_a: assert property (rd_stat0 |=> ahb_out.hrdata[STAT_PLUG_BIT]
    && ahb_out.hrdata[STAT_CAP_LSB +: 3] == CAP_RATE) else $error("Status read lacks plug or capability.");
  rate_clamp_a: assert property (wr_rate0 && !port_in[0].bilingual |=>
    s.pt[0].rate_limit == (($past(ahb_in.hwdata[2:0]) > CAP_RATE) ? CAP_RATE : $past(ahb_in.hwdata[2:0])))
    else $error("Rate limit not clamped to capability.");
  bilingual_hold_a: assert property (wr_rate0 && port_in[0].bilingual |=> $stable(s.pt[0].rate_limit))
    else $error("Bilingual port rate limit changed by write.");
  train_on_connect_a: assert property (!$rose(port_out[0].connected) |-> $stable(port_out[0].train_rate))
    else $error("Training rate changed outside a new connection.");
  unstable_set_a: assert property (port_in[0].neg_fail || port_in[0].sync_fail |=> s.pt[0].unstable)
    else $error("Unstable flag not set on failure.");
  unstable_clear_a: assert property (dp_wr && s.ap_addr == ADDR_STAT && s.sel == '0 &&
    ahb_in.hwdata[STAT_UNSTABLE_BIT] && !port_in[0].neg_fail && !port_in[0].sync_fail |=> !s.pt[0].unstable)
    else $error("Unstable flag not cleared by write of one.");
  errcnt_sat_a: assert property (s.pt[0].errcnt == ERRCNT_MAX && !remote_rd && !ap_take
    |=> s.pt[0].errcnt == ERRCNT_MAX) else $error("Error counter left saturation.");
  errcnt_step_a: assert property (port_in[0].bad_codeword && s.pt[0].errcnt != ERRCNT_MAX && !remote_rd
    && !ap_take |=> s.pt[0].errcnt == $past(s.pt[0].errcnt) + 8'h1) else $error("Error counter missed a word.");
  errcnt_clear_a: assert property (remote_rd && remote_port == 2'h0 && !port_in[0].bad_codeword
    |=> s.pt[0].errcnt == 8'h0 && remote_data == $past(s.pt[0].errcnt)) else $error("Remote read did not clear.");
  sleep_gate_a: assert property ($rose(port_out[0].asleep) |-> $past(s.pt[0].sleep_en))
    else $error("Sleep entered while not enabled.");
  debounce_a: assert property ($rose(port_out[0].connected) |->
    $past(s.pt[0].deb) == DEB_W'(DEBOUNCE_CYC - 1) && $past(port_in[0].line_connect))
    else $error("Connected set before debounce.");
  legacy_report_a: assert property (rd_stat0 |=> ahb_out.hrdata[STAT_LEGACY_BIT] ==
    ($past(s.pt[0].connected) && $past(port_in[0].receive_valid) && !$past(port_in[0].fast_mode)))
    else $error("Legacy activity misreported.");

  conn_seen_c: cover property ($rose(port_out[1].connected) && port_in[1].fast_mode);
  sat_seen_c: cover property (s.pt[0].errcnt == ERRCNT_MAX);
  sleep_seen_c: cover property ($rose(port_out[0].asleep));
  irq_seen_c: cover property ($rose(irq));

endmodule : sbp_port_status

// *** tb/sbp_link_model.sv ***
// Link-layer controller model: an AHB-Lite master that reaches the port status registers.
`timescale 1ns/1ps
module sbp_link_model
  import sbp_pkg::*;
(
  // Clock.
  input wire logic ref_clk,
  // Bus towards the block.
  output sbp_ahb_in_t ahb_in,
  input wire sbp_ahb_out_t ahb_out
);
  sbp_ahb_in_t req = '0;

  ////////////////////////////////////////////////////////////
  // With one slave on the bus, its ready is the bus ready.
  always_comb begin
    ahb_in = req;
    ahb_in.hready = ahb_out.hreadyout;
  end

  // Each phase is held until ready is seen high at an edge, so a slow slave is served too.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    req <= '{hsel:1'b1, haddr:{24'h0, a}, htrans:HTRANS_NONSEQ, hwrite:wr, hsize:3'h2, hwdata:req.hwdata, hready:1'b0};
    do @(posedge ref_clk); while (ahb_out.hreadyout !== 1'b1);
    req <= '{hsel:1'b0, haddr:req.haddr, htrans:2'h0, hwrite:wr, hsize:3'h2, hwdata:d, hready:1'b0};
    do @(posedge ref_clk); while (ahb_out.hreadyout !== 1'b1);
    q = ahb_out.hrdata;
  endtask : xfer

  // Single word write; the data is passed on as given.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : bus_wr

  // Single word read.
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : bus_rd
endmodule : sbp_link_model

// *** tb/test_sbp_port_status.sv ***
// Self-checking bench of the port status register bank.
`timescale 1ns/1ps
module test_sbp_port_status
  import sbp_pkg::*;
;
  localparam int DEB = 8;
  localparam logic [2:0] CAP = RATE_S800;
  localparam logic [31:0] BASE = {28'h0, CAP, 1'b1};
  logic ref_clk;
  logic rst_n;
  sbp_ahb_in_t ahb_in;
  sbp_ahb_out_t ahb_out;
  sbp_port_in_t [2:0] pin;
  sbp_port_out_t [2:0] pout;
  logic sleep_strap;
  logic remote_rd;
  logic [1:0] remote_port;
  logic [7:0] remote_data;
  logic irq;
  int n_mismatch = 0;
  int comparisons = 0;

  // A small debounce count keeps the run short; capability above S400 exposes the bilingual override.
  sbp_port_status #(.NUM_PORTS(3), .CAP_RATE(CAP), .DEBOUNCE_CYC(DEB)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ahb_in(ahb_in), .ahb_out(ahb_out), .port_in(pin), .port_out(pout),
    .sleep_strap(sleep_strap), .remote_rd(remote_rd), .remote_port(remote_port),
    .remote_data(remote_data), .irq(irq));
  sbp_link_model u_link (.ref_clk(ref_clk), .ahb_in(ahb_in), .ahb_out(ahb_out));

  // Clock at 20 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////
  // Helpers.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    u_link.bus_rd(a, q);
    check(q, exp, what);
  endtask : rd_chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset();
    check(32'(pout[0].train_rate), 32'(CAP), "train rst");
    check(32'({ahb_out.hreadyout, ahb_out.hresp}), 32'h2, "ready okay");
    rd_chk(ADDR_CTRL, 32'(CAP), "ctrl rst");
    rd_chk(ADDR_STAT, BASE, "stat rst");
    rd_chk(ADDR_ERRCNT, 32'h0, "err rst");
    rd_chk(8'h18, 32'h0, "unmapped");
  endtask : t_reset

  // Every code, reserved ones too, goes into a plain port; a bilingual port ignores the write.
  task automatic t_rate();
    u_link.bus_wr(ADDR_PORT_SEL, 32'h0);
    for (int c = 0; c < 8; c++) begin
      u_link.bus_wr(ADDR_CTRL, 32'(c));
      rd_chk(ADDR_CTRL, (c > int'(CAP)) ? 32'(CAP) : 32'(c), "clamp");
    end
    // Port 0 turned bilingual for one write: the clamped value from the loop must stay.
    pin[0].bilingual <= 1'b1;
    u_link.bus_wr(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_CTRL, 32'(CAP), "bilingual p0");
    pin[0].bilingual <= 1'b0;
    u_link.bus_wr(ADDR_PORT_SEL, 32'h2);
    u_link.bus_wr(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_CTRL, 32'(CAP), "bilingual");
    rd_chk(ADDR_STAT, BASE | 32'h400, "stat p2");
  endtask : t_rate

  // Both failure kinds set the flag; write one clears it, and the interrupt follows the mask.
  task automatic t_unstable();
    u_link.bus_wr(ADDR_PORT_SEL, 32'h0);
    pin[0].neg_fail <= 1'b1;
    cyc(1);
    pin[0].neg_fail <= 1'b0;
    rd_chk(ADDR_STAT, BASE | 32'h200, "neg fail");
    check(32'(irq), 32'h0, "irq masked");
    u_link.bus_wr(ADDR_IRQ_MASK, 32'h1);
    cyc(1);
    check(32'(irq), 32'h1, "irq");
    u_link.bus_wr(ADDR_STAT, 32'h200);
    rd_chk(ADDR_STAT, BASE, "w1c");
    pin[0].sync_fail <= 1'b1;
    cyc(1);
    pin[0].sync_fail <= 1'b0;
    rd_chk(ADDR_STAT, BASE | 32'h200, "sync fail");
    u_link.bus_wr(ADDR_STAT, 32'h200);
    u_link.bus_wr(ADDR_IRQ_STAT, 32'h1);
    cyc(1);
    check(32'(irq), 32'h0, "irq clr");
  endtask : t_unstable

  // The strap was low, so a request alone must not put the port to sleep.
  task automatic t_sleep();
    pin[0].sleep_req <= 1'b1;
    cyc(4);
    check(32'(pout[0].asleep), 32'h0, "no sleep");
    u_link.bus_wr(ADDR_CTRL, 32'h8 | 32'(CAP));
    cyc(2);
    check(32'(pout[0].asleep), 32'h1, "asleep");
    rd_chk(ADDR_STAT, BASE | 32'h100, "sleep bit");
    pin[0].sleep_req <= 1'b0;
    cyc(3);
    rd_chk(ADDR_STAT, BASE, "awake");
  endtask : t_sleep

  // Port 1 fast at a lowered limit, port 2 bilingual fast, port 0 legacy.
  task automatic t_link();
    u_link.bus_wr(ADDR_PORT_SEL, 32'h1);
    u_link.bus_wr(ADDR_CTRL, 32'(RATE_S200));
    pin[0] <= '{line_connect:1'b1, receive_valid:1'b1, default:1'b0};
    pin[1] <= '{line_connect:1'b1, receive_valid:1'b1, fast_mode:1'b1, default:1'b0};
    pin[2] <= '{line_connect:1'b1, fast_mode:1'b1, bilingual:1'b1, default:1'b0};
    cyc(DEB - 2);
    check(32'(pout[1].connected), 32'h0, "early conn");
    cyc(6);
    check(32'(pout[1].connected), 32'h1, "conn");
    check(32'(pout[1].train_rate), 32'(RATE_S200), "train p1");
    check(32'(pout[2].train_rate), 32'(RATE_S400), "train p2");
    rd_chk(ADDR_STAT, BASE | 32'h70, "fast stat");
    u_link.bus_wr(ADDR_CTRL, 32'(RATE_S100));
    cyc(2);
    check(32'(pout[1].train_rate), 32'(RATE_S200), "no retrain");
    u_link.bus_wr(ADDR_PORT_SEL, 32'h0);
    rd_chk(ADDR_STAT, BASE | 32'hE0, "legacy stat");
  endtask : t_link

  // Saturation, clearing by a local read and by a remote read.
  task automatic t_err();
    pin[0].bad_codeword <= 1'b1;
    cyc(300);
    pin[0].bad_codeword <= 1'b0;
    rd_chk(ADDR_ERRCNT, 32'hFF, "saturate");
    rd_chk(ADDR_ERRCNT, 32'h0, "read clr");
    // Saturation, connection and sleep events are pending; only the unstable bit was cleared.
    rd_chk(ADDR_IRQ_STAT, 32'hE, "irq events");
    rd_chk(ADDR_IRQ_MASK, 32'h1, "irq mask");
    rd_chk(ADDR_PORT_SEL, 32'h0, "port sel");
    pin[0].bad_codeword <= 1'b1;
    cyc(5);
    pin[0].bad_codeword <= 1'b0;
    remote_port <= 2'h0;
    remote_rd <= 1'b1;
    cyc(1);
    remote_rd <= 1'b0;
    #1;
    check(32'(remote_data), 32'h5, "remote");
    rd_chk(ADDR_ERRCNT, 32'h0, "remote clr");
  endtask : t_err

  // A second reset with the strap high: sleep enable follows the strap, the connection restarts.
  task automatic t_strap();
    sleep_strap <= 1'b1;
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    check(32'(pout[0].connected), 32'h0, "conn rst");
    rd_chk(ADDR_CTRL, 32'h8 | 32'(CAP), "strap");
  endtask : t_strap

  ////////////////////////////////////////////////////////////
  // Main sequence: reset held for five cycles, then the scenarios.
  initial begin
    rst_n = 1'b0;
    sleep_strap = 1'b0;
    remote_rd = 1'b0;
    remote_port = 2'h0;
    pin = '0;
    pin[2].bilingual = 1'b1;
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    t_reset();
    t_rate();
    t_unstable();
    t_sleep();
    t_link();
    t_err();
    t_strap();
    give_verdict();
  end

  // Watchdog: the run needs about five hundred cycles, so twenty thousand means a hang.
  initial begin
    #(50 * 20000);
    n_mismatch++;
    give_verdict();
  end
endmodule : test_sbp_port_status
